/* dv/periodic_timer_pin_capture_ctrl_assertions.sv */
// Purpose: Port checker for the periodic timer pin and capture block
// Assumes: Read data stands one cycle after the read strobe
// Notes: Control writes are shadowed to know mode and levels
module periodic_timer_pin_capture_ctrl_assertions #(
  parameter bit WIDE = 1'b1,
  parameter bit UNIT0 = 1'b1
) (
  // Clock and enables
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic tick,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  // Pins
  input wire logic capture_input_pin,
  input wire logic ext_clock_pin,
  input wire logic filtered_data_out,
  input wire logic noise_filter_input_sel,
  input wire logic timerOut,
  input wire logic timerOutEn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl1_reg;
  logic on_reg;
  logic wr0;
  logic rdOk;
  logic isCmp;
  logic pinLvl;
  assign wr0 = regWr && clkEn && regAddr == ptimer_pkg::OFS_CTRL0;
  assign rdOk = regRd && clkEn;
  assign isCmp = ctrl1_reg[7:6] == ptimer_pkg::MODE_CMP;
  assign pinLvl = timerOut ^ ctrl1_reg[ptimer_pkg::BIT_POL];
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl1_reg <= 8'h00;
    end else if (regWr && clkEn && regAddr == ptimer_pkg::OFS_CTRL1) begin
      ctrl1_reg <= regWdata;
    end
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      on_reg <= 1'b0;
    end else if (wr0) begin
      on_reg <= regWdata[ptimer_pkg::BIT_ON];
    end
  end
  // --------
  // Checks
  // --------
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  a_rdata_idle: assert property (clkEn && !regRd |=> regRdata == ptimer_pkg::ZERO_BYTE)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rdOk && regAddr > ptimer_pkg::OFS_PER_HI |=> regRdata == 8'h00)
    else $error("unmapped index read not zero");
  a_clrcfg_top: assert property (rdOk && regAddr == ptimer_pkg::OFS_CLRCFG |=> regRdata[7:3] == 5'h00)
    else $error("clear config upper bits not zero");
  a_ctrl0_low: assert property (rdOk && regAddr == ptimer_pkg::OFS_CTRL0 |=> regRdata[2:0] == 3'h0)
    else $error("control 0 low bits not zero");
  a_outen_mode: assert property (timerOutEn == !ctrl1_reg[6])
    else $error("pin enable disagrees with mode");
  a_on_restore: assert property (wr0 && regWdata[ptimer_pkg::BIT_ON] && !on_reg && isCmp
    |=> ##1 timerOut == (ctrl1_reg[ptimer_pkg::BIT_OC] ^ ctrl1_reg[ptimer_pkg::BIT_POL]))
    else $error("pin not at initial level after counter start");
  a_none_hold: assert property (isCmp && ctrl1_reg[5:4] == ptimer_pkg::PF_NONE && !regWr
    && on_reg && $past(on_reg) |=> $stable(timerOut))
    else $error("pin moved with no-change function");
  a_high_nofall: assert property (isCmp && ctrl1_reg[5:4] == ptimer_pkg::PF_HIGH && !regWr
    && on_reg && $past(on_reg) |=> !$fell(pinLvl))
    else $error("pin fell with go-high function");
  a_low_norise: assert property (isCmp && ctrl1_reg[5:4] == ptimer_pkg::PF_LOW && !regWr
    && on_reg && $past(on_reg) |=> !$rose(pinLvl))
    else $error("pin rose with go-low function");
  a_pwm_forced: assert property (ctrl1_reg[7:6] == ptimer_pkg::MODE_PWM && !ctrl1_reg[5]
    |-> pinLvl == (ctrl1_reg[ptimer_pkg::BIT_OC] ~^ ctrl1_reg[4]))
    else $error("forced PWM level wrong");
  c_start: cover property (wr0 && regWdata[ptimer_pkg::BIT_ON] && isCmp);
  c_toggle: cover property (isCmp && $rose(pinLvl));
  c_capb_read: cover property (rdOk && regAddr == ptimer_pkg::OFS_CMPB_LO);
endmodule : periodic_timer_pin_capture_ctrl_assertions

bind periodic_timer_pin_capture_ctrl periodic_timer_pin_capture_ctrl_assertions #(.WIDE(WIDE), .UNIT0(UNIT0)) i_chk (
  .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .tick(tick), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .capture_input_pin(capture_input_pin),
  .ext_clock_pin(ext_clock_pin), .filtered_data_out(filtered_data_out),
  .noise_filter_input_sel(noise_filter_input_sel), .timerOut(timerOut), .timerOutEn(timerOutEn)
);

/* dv/periodic_timer_pin_capture_ctrl_bench.sv */
// Purpose: Self-checking bench for the periodic timer pin and capture block
// Assumes: 16-bit unit 0 build, clkEn high except for one three-cycle low gap
// Notes: Reads are checked against a queue of expected bytes
module periodic_timer_pin_capture_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0] a;
    logic [7:0] e;
  } note_t;
  note_t notes[$];
  note_t note;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic tick = 1'b0;
  logic clkEn = 1'b1;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic rdSeen = 1'b0;
  logic nfSel = 1'b0;
  logic level = 1'b0;
  logic [1:0] srcSel = 2'd0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00;
  logic [7:0] regRdata;
  logic [7:0] capA;
  logic capPin, extPin, filtPin, timerOut, timerOutEn;
  logic [15:0] seed = 16'h53dd;
  logic [7:0] cf [7] = '{8'h00, 8'h10, 8'h20, 8'h31, 8'h1c, 8'h28, 8'h38};
  logic [7:0] pw [4] = '{8'h88, 8'h98, 8'h90, 8'h80};
  logic [6:0] exB = 7'b1100000;
  logic [6:0] exA = 7'b0111100;
  int nMismatch = 0;
  int nTests = 0;

  periodic_timer_pin_capture_ctrl #(.WIDE(1'b1), .UNIT0(1'b1)) i_periodic_timer_pin_capture_ctrl (
    .sys_clk(sys_clk), .nrst(nrst), .clkEn(clkEn), .tick(tick), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .capture_input_pin(capPin), .ext_clock_pin(extPin),
    .filtered_data_out(filtPin), .noise_filter_input_sel(nfSel), .timerOut(timerOut), .timerOutEn(timerOutEn)
  );
  pin_model i_pin_model (.sys_clk(sys_clk), .srcSel(srcSel), .level(level),
    .capture_input_pin(capPin), .ext_clock_pin(extPin), .filtered_data_out(filtPin));

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    nTests++;
    if (seen !== exp) begin
      nMismatch++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic endSim();
    if (nMismatch == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : endSim
  task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d, input logic t);
    regWr <= w;
    regRd <= r;
    regAddr <= a;
    regWdata <= d;
    tick <= t;
    @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    cyc(1'b1, 1'b0, a, d, 1'b0);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    notes.push_back({a, e});
    cyc(1'b0, 1'b1, a, 8'h00, 1'b0);
  endtask : rd
  task automatic run(input int n, input logic t);
    repeat (n) cyc(1'b0, 1'b0, 4'h0, 8'h00, t);
  endtask : run
  task automatic pinIs(input logic [1:0] ex);
    cyc(1'b0, 1'b0, 4'h0, 8'h00, 1'b0);
    @(negedge sys_clk);
    check("pin", {6'h00, timerOutEn, timerOut}, {6'h00, ex});
    @(posedge sys_clk);
  endtask : pinIs

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    nMismatch++;
    endSim();
  end
  // -------------
  // Result monitor
  // -------------
  always @(posedge sys_clk) rdSeen <= regRd;
  always @(negedge sys_clk) begin
    if (rdSeen) begin
      note = notes.pop_front();
      check($sformatf("reg %h", note.a), regRdata, note.e);
    end
  end
  // -------------
  // Main sequence
  // -------------
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    for (int i = 0; i < 16; i++) rd(i[3:0], 8'h00);
    seed = lfsr(seed);
    wr(4'h7, seed[7:0]);
    wr(4'h8, seed[15:8]);
    wr(4'h5, seed[15:8]);
    wr(4'h3, seed[7:0]);
    wr(4'h2, 8'hff);
    rd(4'h7, seed[7:0]);
    rd(4'h8, seed[15:8]);
    rd(4'h5, seed[15:8]);
    rd(4'h3, 8'h00);
    rd(4'h2, 8'h06);
    wr(4'h2, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(4'h0, 8'h00);
      wr(4'h1, cf[i]);
      wr(4'h5, 8'h03);
      wr(4'h0, 8'h08);
      pinIs({1'b1, exB[i]});
      run(6, 1'b1);
      pinIs({1'b1, exA[i]});
      capA = (i == 3) ? 8'h02 : 8'h06;
      rd(4'h3, capA);
      wr(4'h0, 8'h00);
      run(2, 1'b1);
      rd(4'h3, capA);
      rd(4'h4, 8'h00);
      wr(4'h0, 8'h08);
      pinIs({1'b1, exB[i]});
      rd(4'h3, 8'h00);
    end
    wr(4'h0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(4'h1, pw[i]);
      pinIs({1'b1, i[0]});
    end
    wr(4'h1, 8'hfc);
    pinIs(2'b00);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      srcSel <= (seed[1:0] == 2'd3) ? 2'd0 : seed[1:0];
      nfSel <= seed[1];
      wr(4'h1, {2'b01, i[1:0], 2'b00, ^seed[1:0], 1'b0});
      run(30, 1'b0);
      wr(4'h5, 8'hee);
      wr(4'h0, 8'h08);
      run(5, 1'b1);
      level <= 1'b1;
      run(30, 1'b0);
      capA = (i == 1 || i == 3) ? 8'hee : 8'h04;
      rd(4'h5, capA);
      run(2, 1'b1);
      level <= 1'b0;
      run(30, 1'b0);
      if (i == 1 || i == 2) capA = 8'h06;
      rd(4'h5, capA);
      wr(4'h0, 8'h00);
    end
    srcSel <= 2'd0;
    wr(4'h1, 8'h60);
    wr(4'h2, 8'h02);
    run(30, 1'b0);
    wr(4'h5, 8'hee);
    wr(4'h7, 8'hee);
    wr(4'h0, 8'h08);
    run(4, 1'b1);
    level <= 1'b1;
    run(30, 1'b0);
    rd(4'h7, 8'h03);
    rd(4'h5, 8'hee);
    rd(4'h3, 8'h00);
    rd(4'h2, 8'h03);
    run(3, 1'b1);
    level <= 1'b0;
    run(30, 1'b0);
    rd(4'h5, 8'h03);
    rd(4'h3, 8'h03);
    rd(4'h2, 8'h02);
    wr(4'h0, 8'h00);
    wr(4'h5, 8'h02);
    wr(4'h9, 8'h04);
    wr(4'h1, 8'ha9);
    wr(4'h0, 8'h08);
    pinIs(2'b11);
    run(2, 1'b1);
    pinIs(2'b10);
    clkEn <= 1'b0;
    run(3, 1'b1);
    clkEn <= 1'b1;
    rd(4'h3, 8'h02);
    run(3, 1'b1);
    pinIs(2'b11);
    rd(4'h3, 8'h00);
    wr(4'h0, 8'h00);
    wr(4'h1, 8'hb8);
    wr(4'h0, 8'h08);
    pinIs(2'b11);
    run(3, 1'b1);
    pinIs(2'b10);
    run(2, 1'b0);
    endSim();
  end
endmodule : periodic_timer_pin_capture_ctrl_bench

/* dv/pin_model.sv */
// Purpose: Far-side model driving the capture source pins
// Assumes: srcSel 0 capture pin, 1 ext clock pin, 2 filter data
// Notes: Unselected sources toggle every cycle as noise
module pin_model (
  // Clock
  input wire logic sys_clk,
  // Stimulus
  input wire logic [1:0] srcSel,
  input wire logic level,
  // Capture sources
  output logic capture_input_pin,
  output logic ext_clock_pin,
  output logic filtered_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pins_reg = 3'b000;
  always @(posedge sys_clk) begin
    for (int k = 0; k < 3; k++) begin
      pins_reg[k] <= (srcSel == k[1:0]) ? level : ~pins_reg[k];
    end
  end
  assign capture_input_pin = pins_reg[0];
  assign ext_clock_pin = pins_reg[1];
  assign filtered_data_out = pins_reg[2];
endmodule : pin_model

/* pkg/ptimer_pkg.sv */
// Purpose: Constants and carriers for the periodic timer pin and capture block
// Assumes: 8-bit register port, byte-wide registers at word-free indices
// Notes: Offsets are register indices on the plain register port
package ptimer_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] OFS_CTRL0 = 4'h0;
  localparam logic [3:0] OFS_CTRL1 = 4'h1;
  localparam logic [3:0] OFS_CLRCFG = 4'h2;
  localparam logic [3:0] OFS_CNT_LO = 4'h3;
  localparam logic [3:0] OFS_CNT_HI = 4'h4;
  localparam logic [3:0] OFS_CMPA_LO = 4'h5;
  localparam logic [3:0] OFS_CMPA_HI = 4'h6;
  localparam logic [3:0] OFS_CMPB_LO = 4'h7;
  localparam logic [3:0] OFS_CMPB_HI = 4'h8;
  localparam logic [3:0] OFS_PER_LO = 4'h9;
  localparam logic [3:0] OFS_PER_HI = 4'ha;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int BIT_ON = 3;
  localparam int BIT_CCLR = 0;
  localparam int BIT_CAPTS = 1;
  localparam int BIT_POL = 2;
  localparam int BIT_OC = 3;
  localparam int BIT_VLF = 0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int FILTER_NS = 150;
  localparam int FILTER_CYCLES = FILTER_NS / CLK_PERIOD_NS;
  localparam int FILT_W = 5;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_CAP = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TMR = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    PF_NONE = 2'b00,
    PF_LOW = 2'b01,
    PF_HIGH = 2'b10,
    PF_TOGGLE = 2'b11
  } pin_fn_t;

  localparam logic [1:0] EDGE_RISE = 2'b00;
  localparam logic [1:0] EDGE_FALL = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b10;
  localparam logic [1:0] EDGE_OFF = 2'b11;
  localparam logic [1:0] CLR_P_ONLY = 2'b00;
  localparam logic [1:0] CLR_RISE = 2'b01;
  localparam logic [1:0] CLR_FALL = 2'b10;

  typedef struct packed {
    op_mode_t mode;
    pin_fn_t pinFunc;
    logic initLevel;
    logic invert;
    logic capSrc;
    logic clrSrc;
  } ctrl1_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage : ptimer_pkg

/* verilog/periodic_timer_pin_capture_ctrl.sv */
// Purpose: Periodic timer unit with output pin, capture and counter clear logic
// Assumes: tick is the selected timer clock enable, inputs synchronous to sys_clk
// Notes: WIDE selects 16-bit unit, UNIT0 adds compare B, clear config and filter
//
// Our own choices: the register offsets and the plain strobed port.

// How it works
// R1: Compare-A match in compare mode: none, low, high or toggle by pin function.
// R2: PWM mode pin function: inactive, active, PWM waveform, single pulse.
// R3: Unit 0, clear config 00: capture into A on rise, fall, both, or off.
// R4: Unit 0, clear config nonzero: rise to B, fall to A, both split, or off.
// R5: Units 1-3 capture on rising, falling, both edges, or disabled.
// R6: Compare output changes visibly only if selected level differs from initial level.
// R7: Counter-on rising edge returns pin to its initial level.
// R8: Software changes pin function only while the timer is off.
// R9: Initial level sets pre-match level, PWM active level, single pulse start level.
// R10: Invert flips the pin; invert and initial level unused in timer mode.
// R11: Capture source: capture pin or external clock pin, filtered or noise-filter data on unit 0.
// R12: Clear source 1 clears on compare-A match; 0 on compare-P or overflow.
// R13: Overflow clear only when the period value is all zero.
// R14: Clear source ignored in PWM, single pulse and capture modes.
// R15: Unit 0 capture: clear on P match, plus rise, fall or both edges.
// R16: Read-only latch edge flag: 1 rising, 0 falling trigger of last latch.
// R17: Unit 0 has 16-bit read/write compare B as low and high bytes.
// R18: Counter readable as two bytes; 10-bit units show only bits 9-8 high.
// R19: Compare A low byte is read/write and resets to zero.
// R20: Unimplemented register bits read as zero.
// R21: Pin function has no effect in timer/counter mode.
// R22: Mode select: compare, capture, PWM or single pulse, timer/counter.
// R23: Counter-on rise clears counter; fall stops and holds it.
// R24: Capture inputs synchronised and edge detected, one capture per edge.
module periodic_timer_pin_capture_ctrl #(
  parameter bit WIDE = 1'b1,
  parameter bit UNIT0 = 1'b1
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic tick,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // Pins
  input wire logic capture_input_pin,
  input wire logic ext_clock_pin,
  input wire logic filtered_data_out,
  input wire logic noise_filter_input_sel,
  output logic timerOut,
  output logic timerOutEn
);
  localparam int FILT_W_L = ptimer_pkg::FILT_W;
  localparam logic [15:0] CNT_MASK = WIDE ? 16'hffff : 16'h03ff;

  ptimer_pkg::reg_req_t req;
  assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic counter_on_reg;
  ptimer_pkg::ctrl1_t ctrl1_reg;
  logic [1:0] capture_clear_sel_reg;
  logic latch_edge_flag_reg;
  logic [15:0] cmpA_reg, cmpB_reg, period_reg, count_reg;
  logic [7:0] rdata_reg;
  logic capSync1_reg, capSync2_reg, capPrev_reg;
  logic [FILT_W_L-1:0] filtCnt_reg;
  logic filtLevel_reg;
  logic onPrev_reg;
  logic pin_reg;
  logic pulseDone_reg;

  function automatic logic wr_hit(input ptimer_pkg::reg_req_t r, input logic [3:0] ofs);
    wr_hit = r.wr && (r.addr == ofs);
  endfunction : wr_hit

  // Low byte / high byte write merge, masked to counter width
  function automatic logic [15:0] byte_merge(input logic [15:0] old, input logic hi, input logic [7:0] d);
    logic [15:0] v;
    v = hi ? {d, old[7:0]} : {old[15:8], d};
    byte_merge = v & CNT_MASK;
  endfunction : byte_merge

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      counter_on_reg <= 1'b0;
      ctrl1_reg <= '0;
      capture_clear_sel_reg <= '0;
    end else if (clkEn) begin
      if (wr_hit(req, ptimer_pkg::OFS_CTRL0)) begin
        counter_on_reg <= req.wdata[ptimer_pkg::BIT_ON];
      end
      if (wr_hit(req, ptimer_pkg::OFS_CTRL1)) begin
        ctrl1_reg <= req.wdata; // R22
      end
      if (UNIT0 && wr_hit(req, ptimer_pkg::OFS_CLRCFG)) begin
        capture_clear_sel_reg <= req.wdata[2:1];
      end
    end
  end

  // ----------------------------------------
  // Capture source and edge detect
  // ----------------------------------------
  logic capRaw, capSel, rise, fall;
  assign capRaw = ctrl1_reg.capSrc ? ext_clock_pin : capture_input_pin; // R11

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      capSync1_reg <= 1'b0;
      capSync2_reg <= 1'b0;
    end else if (clkEn) begin
      capSync1_reg <= capRaw; // R24
      capSync2_reg <= capSync1_reg;
    end
  end

  // Pulses shorter than the filter time are dropped
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      filtCnt_reg <= '0;
      filtLevel_reg <= 1'b0;
    end else if (clkEn) begin
      if (capSync2_reg == filtLevel_reg) begin
        filtCnt_reg <= '0;
      end else if (filtCnt_reg == FILT_W_L'(ptimer_pkg::FILTER_CYCLES - 1)) begin
        filtCnt_reg <= '0;
        filtLevel_reg <= capSync2_reg; // R11
      end else begin
        filtCnt_reg <= filtCnt_reg + 1'b1;
      end
    end
  end

  always_comb begin
    if (UNIT0 && ctrl1_reg.capSrc) begin
      capSel = noise_filter_input_sel ? filtered_data_out : filtLevel_reg; // R11
    end else begin
      capSel = capSync2_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      capPrev_reg <= 1'b0;
    end else if (clkEn) begin
      capPrev_reg <= capSel;
    end
  end

  assign rise = capSel && !capPrev_reg; // R24
  assign fall = !capSel && capPrev_reg;

  // ----------------------------------------
  // Capture decode
  // ----------------------------------------
  logic isCap, capToA, capToB, edgeClr;
  logic [1:0] edgeSel;
  assign isCap = ctrl1_reg.mode == ptimer_pkg::MODE_CAP;
  assign edgeSel = ctrl1_reg.pinFunc;

  always_comb begin
    capToA = 1'b0;
    capToB = 1'b0;
    if (isCap && counter_on_reg) begin
      if (!UNIT0 || capture_clear_sel_reg == ptimer_pkg::CLR_P_ONLY) begin
        unique case (edgeSel)
          ptimer_pkg::EDGE_RISE: capToA = rise; // R3 R5
          ptimer_pkg::EDGE_FALL: capToA = fall;
          ptimer_pkg::EDGE_BOTH: capToA = rise || fall;
          ptimer_pkg::EDGE_OFF: capToA = 1'b0;
        endcase
      end else begin
        unique case (edgeSel)
          ptimer_pkg::EDGE_RISE: capToB = rise; // R4
          ptimer_pkg::EDGE_FALL: capToA = fall;
          ptimer_pkg::EDGE_BOTH: begin
            capToA = fall;
            capToB = rise;
          end
          ptimer_pkg::EDGE_OFF: capToA = 1'b0;
        endcase
      end
    end
  end

  always_comb begin
    edgeClr = 1'b0;
    if (UNIT0 && isCap && counter_on_reg) begin
      unique case (capture_clear_sel_reg)
        ptimer_pkg::CLR_P_ONLY: edgeClr = 1'b0; // R15
        ptimer_pkg::CLR_RISE: edgeClr = rise;
        ptimer_pkg::CLR_FALL: edgeClr = fall;
        default: edgeClr = rise || fall;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      latch_edge_flag_reg <= 1'b0;
    end else if (clkEn && (capToA || capToB)) begin
      latch_edge_flag_reg <= rise; // R16
    end
  end

  // ----------------------------------------
  // Counter and compare
  // ----------------------------------------
  logic onRise, matchA, matchP, ovf, clrCnt;
  logic [15:0] cntMasked;
  assign cntMasked = count_reg & CNT_MASK;
  assign onRise = counter_on_reg && !onPrev_reg;
  assign matchA = tick && counter_on_reg && cntMasked == (cmpA_reg & CNT_MASK);
  assign matchP = tick && counter_on_reg && period_reg != '0 && cntMasked == period_reg;
  assign ovf = tick && counter_on_reg && cntMasked == CNT_MASK;

  always_comb begin
    if (ctrl1_reg.mode == ptimer_pkg::MODE_CMP || ctrl1_reg.mode == ptimer_pkg::MODE_TMR) begin
      clrCnt = ctrl1_reg.clrSrc ? matchA : (matchP || (ovf && period_reg == '0)); // R12 R13
    end else begin
      clrCnt = matchP || edgeClr || (ovf && period_reg == '0); // R14
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      onPrev_reg <= 1'b0;
      count_reg <= '0;
    end else if (clkEn) begin
      onPrev_reg <= counter_on_reg;
      if (onRise) begin
        count_reg <= '0; // R23
      end else if (clrCnt) begin
        count_reg <= '0;
      end else if (tick && counter_on_reg) begin
        count_reg <= (count_reg + 16'h0001) & CNT_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cmpA_reg <= '0;
      cmpB_reg <= '0;
      period_reg <= '0;
    end else if (clkEn) begin
      if (capToA) begin
        cmpA_reg <= cntMasked; // R3
      end else if (wr_hit(req, ptimer_pkg::OFS_CMPA_LO) || wr_hit(req, ptimer_pkg::OFS_CMPA_HI)) begin
        cmpA_reg <= byte_merge(cmpA_reg, req.addr == ptimer_pkg::OFS_CMPA_HI, req.wdata); // R19
      end
      if (UNIT0 && capToB) begin
        cmpB_reg <= cntMasked; // R4
      end else if (UNIT0 && (wr_hit(req, ptimer_pkg::OFS_CMPB_LO) || wr_hit(req, ptimer_pkg::OFS_CMPB_HI))) begin
        cmpB_reg <= {(req.addr == ptimer_pkg::OFS_CMPB_HI) ? req.wdata : cmpB_reg[15:8],
                     (req.addr == ptimer_pkg::OFS_CMPB_LO) ? req.wdata : cmpB_reg[7:0]}; // R17
      end
      if (wr_hit(req, ptimer_pkg::OFS_PER_LO) || wr_hit(req, ptimer_pkg::OFS_PER_HI)) begin
        period_reg <= byte_merge(period_reg, req.addr == ptimer_pkg::OFS_PER_HI, req.wdata);
      end
    end
  end

  // ----------------------------------------
  // Output pin
  // ----------------------------------------
  logic pwmActive, pinLevel;
  assign pwmActive = cntMasked < (cmpA_reg & CNT_MASK);

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_reg <= 1'b0;
      pulseDone_reg <= 1'b0;
    end else if (clkEn) begin
      if (onRise) begin
        pin_reg <= ctrl1_reg.initLevel; // R7 R9
        pulseDone_reg <= 1'b0;
      end else if (ctrl1_reg.mode == ptimer_pkg::MODE_CMP && matchA) begin
        unique case (ctrl1_reg.pinFunc)
          ptimer_pkg::PF_NONE: pin_reg <= pin_reg; // R1
          ptimer_pkg::PF_LOW: pin_reg <= 1'b0; // R6
          ptimer_pkg::PF_HIGH: pin_reg <= 1'b1;
          ptimer_pkg::PF_TOGGLE: pin_reg <= !pin_reg;
        endcase
      end else if (ctrl1_reg.mode == ptimer_pkg::MODE_PWM && (matchA || matchP)) begin
        pulseDone_reg <= 1'b1;
      end
    end
  end

  always_comb begin
    pinLevel = pin_reg;
    if (ctrl1_reg.mode == ptimer_pkg::MODE_PWM) begin
      unique case (ctrl1_reg.pinFunc) // R2
        ptimer_pkg::PF_NONE: pinLevel = !ctrl1_reg.initLevel;
        ptimer_pkg::PF_LOW: pinLevel = ctrl1_reg.initLevel;
        ptimer_pkg::PF_HIGH: pinLevel = counter_on_reg && pwmActive ? ctrl1_reg.initLevel : !ctrl1_reg.initLevel;
        ptimer_pkg::PF_TOGGLE: pinLevel = counter_on_reg && !pulseDone_reg ? ctrl1_reg.initLevel
                                                                         : !ctrl1_reg.initLevel;
      endcase
    end
  end

  always_comb begin
    timerOutEn = ctrl1_reg.mode != ptimer_pkg::MODE_TMR && ctrl1_reg.mode != ptimer_pkg::MODE_CAP; // R21
    timerOut = timerOutEn ? (pinLevel ^ ctrl1_reg.invert) : 1'b0; // R10
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= ptimer_pkg::RST_BYTE;
    end else if (clkEn) begin
      rdata_reg <= ptimer_pkg::ZERO_BYTE; // R20
      if (req.rd) begin
        unique case (req.addr)
          ptimer_pkg::OFS_CTRL0: rdata_reg <= 8'(counter_on_reg) << ptimer_pkg::BIT_ON;
          ptimer_pkg::OFS_CTRL1: rdata_reg <= ctrl1_reg;
          ptimer_pkg::OFS_CLRCFG: rdata_reg <= UNIT0 ? {5'h00, capture_clear_sel_reg, latch_edge_flag_reg} : 8'h00;
          ptimer_pkg::OFS_CNT_LO: rdata_reg <= cntMasked[7:0]; // R18
          ptimer_pkg::OFS_CNT_HI: rdata_reg <= cntMasked[15:8];
          ptimer_pkg::OFS_CMPA_LO: rdata_reg <= cmpA_reg[7:0];
          ptimer_pkg::OFS_CMPA_HI: rdata_reg <= cmpA_reg[15:8];
          ptimer_pkg::OFS_CMPB_LO: rdata_reg <= UNIT0 ? cmpB_reg[7:0] : 8'h00;
          ptimer_pkg::OFS_CMPB_HI: rdata_reg <= UNIT0 ? cmpB_reg[15:8] : 8'h00;
          ptimer_pkg::OFS_PER_LO: rdata_reg <= period_reg[7:0];
          ptimer_pkg::OFS_PER_HI: rdata_reg <= period_reg[15:8];
          default: rdata_reg <= ptimer_pkg::ZERO_BYTE;
        endcase
      end
    end
  end

  assign regRdata = rdata_reg;
endmodule : periodic_timer_pin_capture_ctrl
